// [logic/fcm_host.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fcm_cfg.svh"
module fcm_host (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// software port
	input wire logic [2:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	// flash pins
	output fcm_pkg::fcm_pins_s flash,
	output logic dq_oe_n,
	input wire logic [15:0] dq_in
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RDWAIT, ST_DONE} fcm_st_e;

	// ------------------------------------------------------------------
	// step decoding for each operation
	// ------------------------------------------------------------------
	function automatic fcm_pkg::fcm_step_s seq_step(input fcm_pkg::fcm_op_e op,
			input logic [1:0] idx, input logic abort, input logic [21:0] addr);
		fcm_pkg::fcm_step_s s;
		s = '{addr: addr, data: `FCM_RESET_DATA, is_read: 1'b0};
		case (op)
			fcm_pkg::OP_READ: s.is_read = 1'b1;
			fcm_pkg::OP_QUERY: s = '{addr: `FCM_QUERY_ADDR, data: `FCM_QUERY_DATA, is_read: 1'b0};
			default: begin
				// unlock pair first for autoselect or abort reset, then the command word
				if (idx == 2'h0 && (op == fcm_pkg::OP_AUTOSEL || abort)) begin
					s = '{addr: `FCM_U1_ADDR, data: `FCM_U1_DATA, is_read: 1'b0};
				end else if (idx == 2'h1) begin
					s = '{addr: `FCM_U2_ADDR, data: `FCM_U2_DATA, is_read: 1'b0};
				end else if (op == fcm_pkg::OP_AUTOSEL) begin
					s = '{addr: `FCM_U1_ADDR, data: `FCM_AUTOSEL_DATA, is_read: 1'b0};
				end
			end
		endcase
		return s;
	endfunction : seq_step

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	fcm_st_e state_r, state_nxt;
	fcm_pkg::fcm_op_e op_r;
	fcm_pkg::fcm_mode_e mode_r;
	fcm_pkg::fcm_pins_s pins_nxt;
	logic [3:0] ctrl_r;
	logic [21:0] addr_r;
	logic [15:0] rdata_r;
	logic refused_r;
	logic [1:0] idx_r, last_r;
	logic [2:0] cnt_r, cnt_nxt;
	logic [15:0] sync1_r, sync2_r, sync3_r;
	logic dq_oe_n_nxt;

	// ------------------------------------------------------------------
	// software decode and start checks
	// ------------------------------------------------------------------
	wire cmd_wr = sw_wr && sw_addr == `FCM_REG_CMD;
	wire ctrl_wr = sw_wr && sw_addr == `FCM_REG_CTRL;
	wire addr_wr = sw_wr && sw_addr == `FCM_REG_ADDR;
	wire fcm_pkg::fcm_op_e cmd_op = fcm_pkg::fcm_op_e'(sw_wdata[1:0]);
	wire busy = state_r != ST_IDLE;
	wire byte_mode = ctrl_r[`FCM_CTRL_BYTE];
	wire op_active = ctrl_r[`FCM_CTRL_ACTIVE];
	wire abort_pend = ctrl_r[`FCM_CTRL_ABORT];
	// autoselect only from array read mode and never while busy inside
	wire autosel_ok = !op_active && mode_r == fcm_pkg::MODE_READ;
	// query from array read or from autoselect
	wire query_ok = !op_active && mode_r != fcm_pkg::MODE_QUERY;
	wire op_ok = cmd_op == fcm_pkg::OP_AUTOSEL ? autosel_ok :
		cmd_op == fcm_pkg::OP_QUERY ? query_ok : 1'b1;
	wire start = cmd_wr && !busy && op_ok;
	// a command written while busy or out of mode is refused, never half sent
	wire refuse = cmd_wr && !start;
	// reset after a buffer abort needs the three-cycle form
	wire [1:0] last_nxt = cmd_op == fcm_pkg::OP_AUTOSEL ? 2'h2 :
		(cmd_op == fcm_pkg::OP_RESET && abort_pend) ? 2'h2 : 2'h0;
	wire fcm_pkg::fcm_step_s step = seq_step(op_r, idx_r, abort_pend, addr_r);
	// word offsets go out doubled in byte mode
	wire [21:0] pin_addr = byte_mode ? {step.addr[20:0], 1'b0} : step.addr;
	wire last_step = idx_r == last_r;
	// synchronised data counts once stages two and three agree
	wire dq_stable = sync2_r == sync3_r;

	// ------------------------------------------------------------------
	// bus cycle sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		pins_nxt = flash;
		dq_oe_n_nxt = dq_oe_n;
		case (state_r)
			ST_IDLE: if (start) begin
				state_nxt = ST_SETUP;
			end
			ST_SETUP: begin
				// address and data go out with the strobe's fall, held past its rise
				pins_nxt.addr = pin_addr;
				pins_nxt.dq_out = step.data;
				pins_nxt.ce_n = 1'b0;
				if (step.is_read) begin
					pins_nxt.oe_n = 1'b0;
					cnt_nxt = 3'(`FCM_ACC_CYC + `FCM_SYNC_CYC);
					state_nxt = ST_RDWAIT;
				end else begin
					dq_oe_n_nxt = 1'b0;
					pins_nxt.we_n = 1'b0;
					cnt_nxt = 3'(`FCM_WP_CYC);
					state_nxt = ST_STROBE;
				end
			end
			ST_STROBE: begin
				cnt_nxt = cnt_r - 3'h1;
				if (cnt_r == 3'h1) begin
					pins_nxt.we_n = 1'b1;
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// data stays one cycle after the strobe rises
				pins_nxt.ce_n = 1'b1;
				dq_oe_n_nxt = 1'b1;
				state_nxt = last_step ? ST_DONE : ST_SETUP;
			end
			ST_RDWAIT: begin
				if (cnt_r != 3'h0) begin
					cnt_nxt = cnt_r - 3'h1;
				end else if (dq_stable) begin
					pins_nxt.oe_n = 1'b1;
					pins_nxt.ce_n = 1'b1;
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// state and pin registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			flash <= '{addr: 22'h0, dq_out: 16'h0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
			dq_oe_n <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			flash <= pins_nxt;
			dq_oe_n <= dq_oe_n_nxt;
		end
	end

	// step index: advances after each write but the last of a sequence
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idx_r <= 2'h0;
			last_r <= 2'h0;
			op_r <= fcm_pkg::OP_READ;
		end else if (start) begin
			idx_r <= 2'h0;
			last_r <= last_nxt;
			op_r <= cmd_op;
		end else if (state_r == ST_HOLD && !last_step) begin
			idx_r <= idx_r + 2'h1;
		end
	end

	// tracked mode: reset is the only way out of query; autoselect is left by reset or by query
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_r <= fcm_pkg::MODE_READ;
		end else if (state_r == ST_DONE) begin
			case (op_r)
				fcm_pkg::OP_RESET: mode_r <= fcm_pkg::MODE_READ;
				fcm_pkg::OP_AUTOSEL: mode_r <= fcm_pkg::MODE_AUTOSEL;
				fcm_pkg::OP_QUERY: mode_r <= fcm_pkg::MODE_QUERY;
				default: mode_r <= mode_r;
			endcase
		end
	end

	// three-stage input synchroniser on the data pins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 16'h0;
			sync2_r <= 16'h0;
			sync3_r <= 16'h0;
		end else begin
			sync1_r <= dq_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// software registers; refusal flag set wins over the clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `FCM_CTRL_RST;
			addr_r <= 22'h0;
			rdata_r <= 16'h0;
			refused_r <= 1'b0;
		end else begin
			if (ctrl_wr) ctrl_r <= sw_wdata[3:0];
			if (addr_wr) addr_r <= sw_wdata[21:0];
			if (state_r == ST_RDWAIT && cnt_r == 3'h0 && dq_stable) rdata_r <= sync3_r;
			if (refuse) refused_r <= 1'b1;
			else if (cmd_wr) refused_r <= 1'b0;
		end
	end

	// read mux, answered one cycle after the strobe; unmapped reads zero
	wire [31:0] status_word = {28'h0, mode_r, refused_r, busy};
	wire [31:0] rd_mux = sw_addr == `FCM_REG_CTRL ? {28'h0, ctrl_r} :
		sw_addr == `FCM_REG_ADDR ? {10'h0, addr_r} :
		sw_addr == `FCM_REG_STATUS ? status_word :
		sw_addr == `FCM_REG_RDATA ? {16'h0, (byte_mode ? {8'h0, rdata_r[7:0]} : rdata_r)} :
		32'h0;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) sw_rdata <= 32'h0;
		else sw_rdata <= sw_rd ? rd_mux : 32'h0;
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	autosel_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
		start && cmd_op == fcm_pkg::OP_AUTOSEL |-> !op_active && mode_r == fcm_pkg::MODE_READ)
		else $error("autoselect started from a busy or wrong mode");
	query_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_SETUP && op_r == fcm_pkg::OP_QUERY |=>
		flash.dq_out == `FCM_QUERY_DATA && !flash.we_n)
		else $error("query entry word is wrong");
	abort_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
		start && cmd_op == fcm_pkg::OP_RESET && abort_pend |=> last_r == 2'h2)
		else $error("abort reset is not three cycles");
	strobe_shape_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(flash.we_n) |-> !flash.ce_n && flash.oe_n && !dq_oe_n ##1 $stable(flash.dq_out))
		else $error("write strobe without chip select or data");
	unlock_order_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_SETUP && op_r == fcm_pkg::OP_AUTOSEL && idx_r == 2'h0 |=>
		flash.dq_out == `FCM_U1_DATA ##[1:8] state_r == ST_SETUP && idx_r == 2'h1)
		else $error("unlock words out of order");
	leave_autosel_a: assert property (@(posedge ref_clk) disable iff (rst)
		$past(mode_r) == fcm_pkg::MODE_AUTOSEL && mode_r != fcm_pkg::MODE_AUTOSEL |->
		op_r == fcm_pkg::OP_RESET || op_r == fcm_pkg::OP_QUERY)
		else $error("autoselect left without reset");
	autosel_c: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(mode_r == fcm_pkg::MODE_AUTOSEL));
	query_c: cover property (@(posedge ref_clk) disable iff (rst)
		$rose(mode_r == fcm_pkg::MODE_QUERY));
	read_c: cover property (@(posedge ref_clk) disable iff (rst)
		state_r == ST_RDWAIT ##1 state_r == ST_DONE);
	refuse_c: cover property (@(posedge ref_clk) disable iff (rst) refuse);
endmodule : fcm_host
`default_nettype wire

// [pkg/fcm_cfg.svh]
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH
// ----------------------------------------------------------------------
// software register map (word index on the local port)
// ----------------------------------------------------------------------
`define FCM_REG_CTRL 3'h0
`define FCM_REG_ADDR 3'h1
`define FCM_REG_CMD 3'h2
`define FCM_REG_STATUS 3'h3
`define FCM_REG_RDATA 3'h4
// ctrl field positions and reset value
`define FCM_CTRL_BYTE 0
`define FCM_CTRL_ACTIVE 1
`define FCM_CTRL_ESUSP 2
`define FCM_CTRL_ABORT 3
`define FCM_CTRL_RST 4'h0
// status field positions
`define FCM_ST_BUSY 0
`define FCM_ST_REFUSED 1
`define FCM_ST_MODE 2
// ----------------------------------------------------------------------
// command sequence words, values configurable
// ----------------------------------------------------------------------
`define FCM_U1_ADDR 22'h000555
`define FCM_U1_DATA 16'h00aa
`define FCM_U2_ADDR 22'h0002aa
`define FCM_U2_DATA 16'h0055
`define FCM_AUTOSEL_DATA 16'h0090
`define FCM_RESET_DATA 16'h00f0
`define FCM_QUERY_ADDR 22'h000055
`define FCM_QUERY_DATA 16'h0098
// ----------------------------------------------------------------------
// timing: ns figures and derived cycle counts at 40 ns
// ----------------------------------------------------------------------
`define FCM_CLK_NS 40
`define FCM_T_WP_NS 35
`define FCM_T_ACC_NS 90
`define FCM_WP_CYC ((`FCM_T_WP_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`define FCM_ACC_CYC ((`FCM_T_ACC_NS + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
// extra wait covering the three-stage input synchroniser
`define FCM_SYNC_CYC 3
`endif

// [pkg/fcm_pkg.sv]
package fcm_pkg;
	// ------------------------------------------------------------------
	// operations and tracked device modes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {OP_READ, OP_RESET, OP_AUTOSEL, OP_QUERY} fcm_op_e;
	typedef enum logic [1:0] {MODE_READ, MODE_AUTOSEL, MODE_QUERY} fcm_mode_e;
	// one bus step of a command sequence
	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
		logic is_read;
	} fcm_step_s;
	// flash pins driven by the controller
	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] dq_out;
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fcm_pins_s;
endpackage : fcm_pkg

// [tb/fcm_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// behavioural flash device: command decoder and identifier tables
// ------------------------------------------------------------------
module fcm_flash_model #(
	parameter logic [15:0] MFR_ID = 16'h005a, // arbitrary value
	parameter logic [15:0] DEV_ID1 = 16'h1101, // arbitrary value
	parameter logic [15:0] DEV_ID2 = 16'h1102, // arbitrary value
	parameter logic [15:0] DEV_ID3 = 16'h1103, // arbitrary value
	parameter logic [15:0] LOCK_ST = 16'h0081,
	parameter logic [7:0] BOOT_FLAG = 8'h02
) (
	// pins from the controller
	input wire fcm_pkg::fcm_pins_s pins,
	input wire logic byte_mode,
	input wire logic [15:0] dq_bus,
	// read data towards the bus
	output logic [15:0] dq_drv
);
	localparam logic [15:0] QT [17] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033,
		16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0001,
		16'h00b5, 16'h00c5, {8'h00, BOOT_FLAG}, 16'h0001};
	logic [21:0] a_lat;
	logic [1:0] mode_r = 2'h0; // array read from power-up, no command needed
	logic [1:0] step_r = 2'h0;
	logic [15:0] last_r = 16'h0000;
	logic [15:0] rd_val;
	wire wr_act = !pins.ce_n && !pins.we_n;
	wire rd_act = !pins.ce_n && !pins.oe_n && pins.we_n;
	wire rd_ok;
	wire [21:0] w_off = byte_mode ? {1'b0, pins.addr[21:1]} : pins.addr;
	// data only after the access time, short pulses are filtered out
	assign #90 rd_ok = rd_act;
	// a released bus shows the inverse of the last value, never a held copy
	assign dq_drv = (rd_act && rd_ok) ? rd_val : ~last_r;
	always @(rd_act, rd_ok, rd_val) if (rd_act && rd_ok) last_r = rd_val;
	// address taken on the later falling strobe
	always @(posedge wr_act) a_lat = w_off;
	// data taken on the first rising strobe
	always @(negedge wr_act) begin
		if (dq_bus[7:0] == 8'hf0) begin
			mode_r = 2'h0; // address bits ignored
			// a half-written unlock sequence is dropped as well
			step_r = 2'h0;
		end else if (a_lat == 22'h55 && dq_bus[7:0] == 8'h98 && mode_r != 2'h2) begin
			mode_r = 2'h2;
		end else if (step_r == 2'h0 && a_lat[11:0] == 12'h555 && dq_bus[7:0] == 8'haa) begin
			step_r = 2'h1;
		end else if (step_r == 2'h1 && a_lat[11:0] == 12'h2aa && dq_bus[7:0] == 8'h55) begin
			step_r = 2'h2;
		end else begin
			if (step_r == 2'h2 && dq_bus[7:0] == 8'h90 && mode_r == 2'h0)
				mode_r = 2'h1;
			step_r = 2'h0; // any other write drops the sequence
		end
	end
	// read data by mode
	always_comb begin
		// array pattern; no erase ever runs here, so no sector is held back
		rd_val = ~w_off[15:0];
		if (mode_r == 2'h2 && w_off[7:0] >= 8'h40 && w_off[7:0] <= 8'h50)
			rd_val = QT[5'(w_off[7:0] - 8'h40)];
		else if (mode_r == 2'h2)
			rd_val = 16'h0000;
		else if (mode_r == 2'h1) begin
			case (w_off[7:0])
				8'h00: rd_val = MFR_ID;
				8'h01: rd_val = DEV_ID1;
				8'h0e: rd_val = DEV_ID2;
				8'h0f: rd_val = DEV_ID3;
				8'h03: rd_val = LOCK_ST;
				8'h02: rd_val = 16'h0001; // sector protected
				default: rd_val = 16'h0000;
			endcase
		end
	end
endmodule : fcm_flash_model
`default_nettype wire

// [tb/flash_command_mode_control_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fcm_cfg.svh"
// ------------------------------------------------------------------
// bench: software port stimulus against the flash model
// ------------------------------------------------------------------
module flash_command_mode_control_test;
	localparam logic [15:0] QT [17] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033,
		16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0001,
		16'h00b5, 16'h00c5, 16'h0002, 16'h0001};
	localparam logic [21:0] IDA [6] = '{22'h0, 22'h1, 22'he, 22'hf, 22'h3, 22'h102};
	localparam logic [15:0] IDV [6] = '{16'h005a, 16'h1101, 16'h1102, 16'h1103, 16'h0081,
		16'h0001};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] sw_addr = 3'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [31:0] sw_rdata;
	fcm_pkg::fcm_pins_s flash;
	logic dq_oe_n;
	logic [15:0] dq_drv;
	logic byte_mode = 1'b0;
	logic [31:0] rd;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int n_we = 0;
	// wire level: controller wins while its enable is low
	wire [15:0] dq_wire = !dq_oe_n ? flash.dq_out : dq_drv;
	always #20 ref_clk = ~ref_clk;
	// falling write strobes on the pins, so each command's word count can be judged
	always @(negedge flash.we_n) n_we++;
	fcm_host dut (.ref_clk(ref_clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash(flash),
		.dq_oe_n(dq_oe_n), .dq_in(dq_wire));
	fcm_flash_model model (.pins(flash), .byte_mode(byte_mode), .dq_bus(dq_wire),
		.dq_drv(dq_drv));
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// a hung handshake must not stall the run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rdr(input logic [2:0] a);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1 rd = sw_rdata;
	endtask : rdr
	// status polling until not busy; rd keeps the last status
	task automatic wait_idle;
		for (int i = 0; i < 100; i++) begin
			rdr(`FCM_REG_STATUS);
			if (rd[`FCM_ST_BUSY] === 1'b0) break;
		end
	endtask : wait_idle
	// command then wait; a second command while busy would be refused
	task automatic cmd(input logic [1:0] op);
		wr(`FCM_REG_CMD, {30'h0, op});
		wait_idle();
	endtask : cmd
	task automatic peek(input logic [21:0] a);
		wr(`FCM_REG_ADDR, {10'h0, a});
		cmd(2'h0);
		rdr(`FCM_REG_RDATA);
	endtask : peek
	task automatic t_reset;
		rdr(`FCM_REG_CTRL);
		chk("ctrl reset", rd, 32'h0);
		rdr(`FCM_REG_STATUS);
		chk("status reset", rd, 32'h0);
		rdr(3'h7); // unmapped place, reads zero, not checked
		peek(22'h001234);
		chk("array read", rd, 32'h0000edcb);
		$display("test reset done");
	endtask : t_reset
	task automatic t_query;
		int w0;
		cmd(2'h3);
		chk("query mode", rd[3:0], 4'b1000);
		for (int i = 0; i < 17; i++) begin
			peek(22'h40 + 22'(i));
			chk("query word", rd, {16'h0, QT[i]});
		end
		cmd(2'h3);
		chk("query again", rd[3:0], 4'b1010);
		w0 = n_we;
		cmd(2'h1);
		chk("query exit", rd[3:0], 4'b0000);
		chk("reset words", n_we - w0, 32'h1);
		$display("test query done");
	endtask : t_query
	task automatic t_autosel;
		int w0;
		w0 = n_we;
		wr(`FCM_REG_CMD, 32'h2);
		rdr(`FCM_REG_STATUS);
		chk("busy", rd[0], 1'b1);
		wait_idle();
		chk("autosel mode", rd[3:0], 4'b0100);
		chk("autosel words", n_we - w0, 32'h3);
		for (int i = 0; i < 6; i++) begin
			peek(IDA[i]);
			chk("id word", rd, {16'h0, IDV[i]});
		end
		cmd(2'h2);
		chk("autosel again", rd[3:0], 4'b0110);
		cmd(2'h3);
		chk("query from id", rd[3:0], 4'b1000);
		peek(22'h40);
		chk("query sig", rd, 32'h50);
		cmd(2'h1);
		chk("id exit", rd[3:0], 4'b0000);
		peek(22'h41);
		chk("array again", rd, 32'h0000ffbe);
		$display("test autoselect done");
	endtask : t_autosel
	task automatic t_byte;
		wr(`FCM_REG_CTRL, 32'h1);
		byte_mode = 1'b1;
		cmd(2'h3);
		chk("byte query", rd[3:0], 4'b1000);
		peek(22'h40);
		chk("byte sig", rd, 32'h50);
		peek(22'h4f);
		chk("byte boot", rd, 32'h02);
		cmd(2'h1);
		wr(`FCM_REG_CTRL, 32'h0);
		byte_mode = 1'b0;
		$display("test byte mode done");
	endtask : t_byte
	task automatic t_abort;
		int w0;
		wr(`FCM_REG_CTRL, 32'h2);
		w0 = n_we;
		cmd(2'h2);
		chk("id while active", rd[3:0], 4'b0010);
		cmd(2'h3);
		chk("query while active", rd[3:0], 4'b0010);
		chk("no words while active", n_we - w0, 32'h0);
		wr(`FCM_REG_CTRL, 32'h0);
		cmd(2'h2);
		wr(`FCM_REG_CTRL, 32'h8);
		w0 = n_we;
		cmd(2'h1);
		chk("abort reset", rd[3:0], 4'b0000);
		chk("abort words", n_we - w0, 32'h3);
		peek(22'h5);
		chk("array after abort", rd, 32'h0000fffa);
		wr(`FCM_REG_CTRL, 32'h0);
		$display("test abort done");
	endtask : t_abort
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_query();
		t_autosel();
		t_byte();
		t_abort();
		print_verdict();
	end
endmodule : flash_command_mode_control_test
`default_nettype wire
